// ===== wet_cfg_pkg.sv
// Constants for the upper wetting-current configuration block
package wet_cfg_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] CFG_INDEX = 8'h1E;
  localparam logic [7:0] SEL_INDEX = 8'h30;
  localparam logic [7:0] STAT_INDEX = 8'h31;
  localparam logic [7:0] CFG_ADDR = 8'h78;
  localparam logic [7:0] SEL_ADDR = 8'hC0;
  localparam logic [7:0] STAT_ADDR = 8'hC4;
  // Configuration fields
  localparam int CFG_WIDTH = 24;
  localparam int FIELD_WIDTH = 3;
  localparam int FIELD_COUNT = 7;
  localparam int PAIR_FIELDS = 5;
  localparam int INPUT_COUNT = 12;
  localparam int FIRST_INPUT = 12;
  localparam int RESERVED_BIT = 23;
  localparam int SINK_DIS_BIT = 22;
  localparam int SOURCE_DIS_BIT = 21;
  localparam logic [23:0] CFG_RW_MASK = 24'h7FFFFF;
  localparam logic [23:0] CFG_RESET = 24'h000000;
  localparam logic [9:0] SEL_RESET = 10'h000;
  // Wetting-current codes and applied levels
  localparam logic [2:0] CODE_OFF = 3'h0;
  localparam logic [2:0] CODE_10MA = 3'h4;
  localparam logic [2:0] LVL_OFF = 3'h0;
  localparam logic [2:0] LVL_1MA = 3'h1;
  localparam logic [2:0] LVL_2MA = 3'h2;
  localparam logic [2:0] LVL_5MA = 3'h3;
  localparam logic [2:0] LVL_10MA = 3'h4;
  localparam logic [2:0] LVL_15MA = 3'h5;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== wet_level_decode.sv
// Decodes one wetting-current code into the level applied to one input
`timescale 1ns/1ps
`default_nettype none
module wet_level_decode
(
  // Programmed setting
  input wire logic [2:0] code,
  input wire logic is_sink,
  input wire logic sink_dis,
  input wire logic source_dis,
  // Front-end state
  input wire logic continuous,
  input wire logic closed,
  // Applied level
  output logic [2:0] level,
  output logic scaled
);
  logic [2:0] nominal;
  logic allow;

  // Code to nominal level; codes above 4 all select the top level
  always_comb
  begin
    unique case (code)
      3'h0: nominal = wet_cfg_pkg::LVL_OFF;
      3'h1: nominal = wet_cfg_pkg::LVL_1MA;
      3'h2: nominal = wet_cfg_pkg::LVL_2MA;
      3'h3: nominal = wet_cfg_pkg::LVL_5MA;
      3'h4: nominal = wet_cfg_pkg::LVL_10MA;
      default: nominal = wet_cfg_pkg::LVL_15MA;
    endcase
  end

  // Auto-scaling: in continuous mode, high currents drop to 2 mA while the input is closed
  assign allow = is_sink ? !sink_dis : !source_dis;
  assign scaled = allow && continuous && closed
                  && (code >= wet_cfg_pkg::CODE_10MA);
  assign level = scaled ? wet_cfg_pkg::LVL_2MA : nominal;
endmodule
`default_nettype wire

// ===== wet_cfg_upper.sv
// Upper wetting-current configuration register with AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none
module wet_cfg_upper
#(
  parameter int NUM_SEL = 10,
  parameter logic [11:0] FIXED_SINK = 12'h000
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Front-end state, same clock
  input wire logic continuous_mode,
  input wire logic [11:0] switch_closed,
  // Applied levels for inputs 12 to 23, and scaling permission for 0 to 9
  output logic [35:0] wet_level_out,
  output logic [9:0] autoscale_allow
);
  typedef struct packed {
    logic [23:0] cfg;
    logic [9:0] sel;
    logic [35:0] level;
    logic [11:0] scaled;
    logic [9:0] allow;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t q_r;
  state_t q_nxt;
  logic [35:0] lvl_w;
  logic [11:0] scaled_w;
  logic wr_go;
  logic rd_go;

  if (NUM_SEL < 1 || NUM_SEL > 10)
  begin : g_check
    $error("NUM_SEL must lie between 1 and 10");
  end

  // One decoder per input; pairs read the same field
  for (genvar i = 0; i < wet_cfg_pkg::INPUT_COUNT; i++)
  begin : g_input
    localparam int F = (i < 2 * wet_cfg_pkg::PAIR_FIELDS) ? i / 2 : i - wet_cfg_pkg::PAIR_FIELDS;
    wet_level_decode u_dec
    (
      .code(q_r.cfg[F * 3 +: 3]),
      .is_sink(FIXED_SINK[i]),
      .sink_dis(q_r.cfg[wet_cfg_pkg::SINK_DIS_BIT]),
      .source_dis(q_r.cfg[wet_cfg_pkg::SOURCE_DIS_BIT]),
      .continuous(continuous_mode),
      .closed(switch_closed[i]),
      .level(lvl_w[i * 3 +: 3]),
      .scaled(scaled_w[i])
    );
  end

  // Handshakes: a write needs both channels and no pending response
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !q_r.bvalid;
  assign rd_go = s_axi_arvalid && !q_r.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  // Next state: register writes, reads, and applied levels
  always_comb
  begin
    logic [23:0] wmask;
    wmask = {{8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    q_nxt = q_r;
    q_nxt.level = lvl_w;
    q_nxt.scaled = scaled_w;
    for (int k = 0; k < 10; k++)
    begin
      q_nxt.allow[k] = (k < NUM_SEL) && (q_r.sel[k] ? !q_r.cfg[wet_cfg_pkg::SINK_DIS_BIT]
                       : !q_r.cfg[wet_cfg_pkg::SOURCE_DIS_BIT]);
    end
    if (q_r.bvalid && s_axi_bready)
    begin
      q_nxt.bvalid = 1'b0;
    end
    if (q_r.rvalid && s_axi_rready)
    begin
      q_nxt.rvalid = 1'b0;
    end
    if (wr_go)
    begin
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = wet_cfg_pkg::RESP_OKAY;
      unique case (s_axi_awaddr)
        wet_cfg_pkg::CFG_ADDR:
          q_nxt.cfg = ((q_r.cfg & ~wmask) | (s_axi_wdata[23:0] & wmask))
                      & wet_cfg_pkg::CFG_RW_MASK;
        wet_cfg_pkg::SEL_ADDR:
        begin
          if (s_axi_wstrb[0])
          begin
            q_nxt.sel[7:0] = s_axi_wdata[7:0];
          end
          if (s_axi_wstrb[1])
          begin
            q_nxt.sel[9:8] = s_axi_wdata[9:8];
          end
        end
        wet_cfg_pkg::STAT_ADDR: q_nxt.bresp = wet_cfg_pkg::RESP_OKAY;
        default: q_nxt.bresp = wet_cfg_pkg::RESP_SLVERR;
      endcase
    end
    if (rd_go)
    begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = wet_cfg_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        wet_cfg_pkg::CFG_ADDR: q_nxt.rdata = {8'h00, q_r.cfg};
        wet_cfg_pkg::SEL_ADDR: q_nxt.rdata = {22'h000000, q_r.sel};
        wet_cfg_pkg::STAT_ADDR: q_nxt.rdata = {20'h00000, q_r.scaled};
        default:
        begin
          q_nxt.rdata = 32'h00000000;
          q_nxt.rresp = wet_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // State register; reset leaves every level off, and the first clock after release sets every scaling permission below NUM_SEL
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_bvalid = q_r.bvalid;
  assign s_axi_bresp = q_r.bresp;
  assign s_axi_rvalid = q_r.rvalid;
  assign s_axi_rresp = q_r.rresp;
  assign s_axi_rdata = q_r.rdata;
  assign wet_level_out = q_r.level;
  assign autoscale_allow = q_r.allow;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Checks on the applied levels and register contents
  a_off_code: assert property (q_r.cfg[20:18] == wet_cfg_pkg::CODE_OFF
    |=> wet_level_out[35:33] == wet_cfg_pkg::LVL_OFF) else $error("code 0 not off");
  a_code_five: assert property (q_r.cfg[2:0] == 3'h3
    |=> wet_level_out[2:0] == wet_cfg_pkg::LVL_5MA) else $error("code 3 not 5 mA");
  a_top_codes: assert property (q_r.cfg[17:15] >= 3'h5 && !switch_closed[10]
    |=> wet_level_out[32:30] == wet_cfg_pkg::LVL_15MA) else $error("high code not 15 mA");
  a_pair_share: assert property (switch_closed[4] == switch_closed[5]
    && FIXED_SINK[4] == FIXED_SINK[5]
    |=> wet_level_out[14:12] == wet_level_out[17:15]) else $error("pair levels differ");
  a_sink_scale: assert property (FIXED_SINK[11] && !q_r.cfg[22] && continuous_mode
    && switch_closed[11] && q_r.cfg[20:18] >= 3'h4
    |=> wet_level_out[35:33] == wet_cfg_pkg::LVL_2MA) else $error("sink not scaled");
  a_source_scale: assert property (!FIXED_SINK[0] && !q_r.cfg[21] && continuous_mode
    && switch_closed[0] && q_r.cfg[2:0] >= 3'h4
    |=> wet_level_out[2:0] == wet_cfg_pkg::LVL_2MA) else $error("source not scaled");
  a_scale_kept: assert property (!FIXED_SINK[0] && q_r.cfg[21] && q_r.cfg[2:0] == 3'h4
    |=> wet_level_out[2:0] == wet_cfg_pkg::LVL_10MA) else $error("10 mA not kept");
  a_reserved_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[23]
    && !q_r.cfg[wet_cfg_pkg::RESERVED_BIT]) else $error("reserved bit set");
  a_reset_clear: assert property ($past(rst) |-> q_r.cfg == wet_cfg_pkg::CFG_RESET
    && q_r.sel == wet_cfg_pkg::SEL_RESET) else $error("register not cleared by reset");
  a_sel_allow: assert property (q_r.sel[0]
    |=> autoscale_allow[0] == !$past(q_r.cfg[22])) else $error("sink selection ignored");

  // Bus answers and configuration writes
  a_write_answer: assert property (wr_go
    |=> s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (rd_go
    |=> s_axi_rvalid) else $error("read not answered");
  a_cfg_write: assert property (wr_go && s_axi_awaddr == wet_cfg_pkg::CFG_ADDR
    && (&s_axi_wstrb[2:0])
    |=> q_r.cfg == ($past(s_axi_wdata[23:0]) & wet_cfg_pkg::CFG_RW_MASK))
    else $error("configuration write lost");
endmodule
`default_nettype wire

// ===== tb_wet_cfg_upper.sv
// Self-checking bench for the upper wetting-current register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic arvalid = 1'h0;
  logic cont = 1'h0;
  logic [31:0] wdata = 32'h00000000;
  logic [11:0] closed = 12'h000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, got;
  logic [35:0] lvl;
  logic [9:0] allow, allow_e;
  logic [35:0] lvl_e;
  logic [11:0] st_e;
  // Inputs 16, 17, 22 and 23 are current sinks, the rest current sources
  localparam logic [11:0] SINK_MAP = 12'hC30;
  logic [31:0] rnd = 87411;
  logic [31:0] cfg_m = 32'h0;
  logic [31:0] sel_m = 32'h0;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  // Device under test; responses are always accepted at once
  wet_cfg_upper #(.FIXED_SINK(SINK_MAP)) u_dut
  (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'h1), .continuous_mode(cont), .switch_closed(closed),
    .wet_level_out(lvl), .autoscale_allow(allow)
  );

  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      $display("mismatch timeout expected %0d seen %0d", 19999, cyc);
      conclude();
    end
  end

  // Next pseudo-random word
  function automatic logic [31:0] lf(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected applied levels of inputs 12 to 23; also fills the expected status
  function automatic logic [35:0] exp_lvl();
    logic [35:0] e;
    int c;
    e = '0;
    st_e = '0;
    for (int i = 0; i < 12; i++)
    begin
      c = (cfg_m >> (3 * (i < 10 ? i / 2 : i - 5))) & 7;
      if (c > 5) c = 5;
      if (c >= 4 && cont && closed[i] && !cfg_m[SINK_MAP[i] ? 22 : 21])
      begin
        c = 2;
        st_e[i] = 1'h1;
      end
      e[3*i+:3] = 3'(c);
    end
    return e;
  endfunction

  // Register write, both channels offered together
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge clk); while (!bvalid);
    resp = bresp;
  endtask

  // Register read
  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    got = rdata;
    resp = rresp;
  endtask

  task chk(input string nm, input logic [35:0] e, input logic [35:0] s);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] c;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(wet_cfg_pkg::CFG_ADDR);
    chk("cfg reset", 36'h0, got);
    rd(wet_cfg_pkg::SEL_ADDR);
    chk("sel reset", 36'h0, got);
    @(negedge clk);
    chk("level reset", 36'h0, lvl);
    chk("allow reset", 36'h3FF, allow);
    $display("test reset done");
    @(posedge clk);
    wr(8'h10, 32'hFFFFFFFF);
    chk("unmapped bresp", 36'h2, resp);
    rd(8'h10);
    chk("unmapped rdata", 36'h0, got);
    chk("unmapped rresp", 36'h2, resp);
    wr(wet_cfg_pkg::STAT_ADDR, 32'hFFFFFFFF);
    chk("status bresp", 36'h0, resp);
    $display("test unmapped done");
    for (int i = 0; i < 32; i++)
    begin
      rnd = lf(rnd);
      c = rnd;
      if (i < 8)
        for (int f = 0; f < 7; f++) c[3*f+:3] = 3'(i + f);
      wr(wet_cfg_pkg::CFG_ADDR, c);
      chk("cfg bresp", 36'h0, resp);
      cfg_m = c & 32'h007FFFFF;
      rnd = lf(rnd);
      wr(wet_cfg_pkg::SEL_ADDR, rnd);
      chk("sel bresp", 36'h0, resp);
      sel_m = rnd & 32'h000003FF;
      cont <= rnd[19] | rnd[7];
      closed <= rnd[31:20];
      rd(wet_cfg_pkg::CFG_ADDR);
      chk("cfg read", cfg_m, got);
      rd(wet_cfg_pkg::SEL_ADDR);
      chk("sel read", sel_m, got);
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int k = 0; k < 10; k++) allow_e[k] = sel_m[k] ? !cfg_m[22] : !cfg_m[21];
      lvl_e = exp_lvl();
      chk("levels", lvl_e, lvl);
      chk("allow", allow_e, allow);
      @(posedge clk);
      rd(wet_cfg_pkg::STAT_ADDR);
      chk("status", st_e, got);
    end
    $display("test levels done");
    // Reset again in mid-run with a non-zero configuration in place
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    cfg_m = 32'h0;
    @(posedge clk);
    rd(wet_cfg_pkg::CFG_ADDR);
    chk("cfg second reset", 36'h0, got);
    rd(wet_cfg_pkg::SEL_ADDR);
    chk("sel second reset", 36'h0, got);
    @(negedge clk);
    lvl_e = exp_lvl();
    chk("level second reset", lvl_e, lvl);
    $display("test second reset done");
    conclude();
  end
endmodule
`default_nettype wire
